// ==== rtl/pmsnap_regs.sv ====
// Snapshot shadow registers and counter enable set/clear bank.
// Assumes live counters run on pclk; snapshot request comes from another domain.
`timescale 1ns/100ps

// What this block does
// - Non-secure accesses pass only if either secure-control override bit is set.
// - Snapshot status bit 0 reads 1 if no capture, else the inverse of event 0 enable at capture; rest zero.
// - A capture copies counter overflow status into overflow snapshot bits 7:0.
// - Low cycle snapshot holds captured cycle counter bits 31:0.
// - High cycle snapshot holds bits 63:32 from the same capture.
// - Eight 32-bit event snapshot registers each take their counter on capture.
// - Writing 1 to capture register bit 0 captures all counters and overflow.
// - Status and overflow snapshot exist as one copy per event counter.
// - Enable-set bit 31 reads cycle enable; writing 1 enables, 0 ignored.
// - Enable-set bits 7:0 read event enables; writing 1 enables; 30:8 reserved.
// - Enable-clear bit 31 reads cycle enable; writing 1 disables, 0 ignored.
// - Enable-clear bits 7:0 read event enables; writing 0 changes nothing.
// - Writing 1 to enable-clear bit disables counter, seen through both registers.
// - Overflow of a counter with its trigger bit set causes a capture.
module pmsnap_regs (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire pmsnap_pkg::pmsnap_apb_req_t apb_req,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire pmsnap_pkg::pmsnap_counts_t  counts,
   input  wire logic [7:0]                 overflow_pulse,
   input  wire logic                       snapshot_request_in,
   output pmsnap_pkg::pmsnap_enable_t      counter_enable,
   output logic                            irq
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0]       rdata;
      logic              ready;
      logic              err;
      logic [1:0]        req_sync;
      logic              req_seen;
      pmsnap_pkg::pmsnap_enable_t enable;
      logic [1:0]        secure_ctrl;
      logic [7:0]        trig_en;
      logic [7:0]        no_capture;
      logic [7:0][7:0]   ovf_copy;
      logic [63:0]       cyc_snap;
      logic [7:0][31:0]  evt_snap;
      logic [pmsnap_pkg::IRQ_W-1:0] irq_status;
      logic [pmsnap_pkg::IRQ_W-1:0] irq_mask;
      logic              irq;
   } pmsnap_state_t;

   pmsnap_state_t state;
   pmsnap_state_t next_state;

   // ==========================================================
   // Address decode
   function automatic logic in_block(input logic [11:0] addr, input logic [11:0] base);
      in_block = (addr >= base) && (addr < base + 12'h020);
   endfunction : in_block

   function automatic logic [2:0] word_index(input logic [11:0] addr);
      word_index = addr[4:2];
   endfunction : word_index

   logic        setup;
   logic        commit;
   logic        allowed;
   logic        mapped;
   logic        wr;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] rd_value;
   logic        req_rise;
   logic        sw_capture;
   logic        ovf_capture;
   logic        capture;
   logic [11:0] addr;

   assign addr    = apb_req.paddr;
   assign setup   = apb_req.psel && !apb_req.penable;
   assign commit  = apb_req.psel && apb_req.penable && state.ready;
   assign allowed = !apb_req.pprot[1] || (|state.secure_ctrl);
   assign wr      = commit && apb_req.pwrite && !state.err;

   generate
      for (genvar b = 0; b < 4; b++) begin : g_lane
         assign wmask[8*b +: 8] = {8{apb_req.pstrb[b]}};
      end
   endgenerate

   assign wbits = apb_req.pwdata & wmask;

   // ==========================================================
   // Read mux and map check
   always_comb begin
      rd_value = 32'h0000_0000;
      mapped   = 1'b1;
      if (addr == pmsnap_pkg::OFF_SNAP_STATUS) begin
         rd_value[pmsnap_pkg::BIT_NO_CAPTURE] = state.no_capture[0];
      end else if (addr == pmsnap_pkg::OFF_OVF_SNAP) begin
         rd_value[7:0] = state.ovf_copy[0];
      end else if (addr == pmsnap_pkg::OFF_CYC_SNAP_LO) begin
         rd_value = state.cyc_snap[31:0];
      end else if (addr == pmsnap_pkg::OFF_CYC_SNAP_HI) begin
         rd_value = state.cyc_snap[63:32];
      end else if (in_block(addr, pmsnap_pkg::OFF_EVT_SNAP)) begin
         rd_value = state.evt_snap[word_index(addr)];
      end else if (addr == pmsnap_pkg::OFF_CAPTURE) begin
         rd_value = 32'h0000_0000;
      end else if (addr == pmsnap_pkg::OFF_ENABLE_SET || addr == pmsnap_pkg::OFF_ENABLE_CLR) begin
         rd_value[pmsnap_pkg::BIT_CYCLE_EN] = state.enable.cycle;
         rd_value[7:0] = state.enable.events;
      end else if (addr == pmsnap_pkg::OFF_SECURE_CTRL) begin
         rd_value[1:0] = state.secure_ctrl;
      end else if (addr == pmsnap_pkg::OFF_OVF_TRIG_EN) begin
         rd_value[7:0] = state.trig_en;
      end else if (addr == pmsnap_pkg::OFF_IRQ_STATUS) begin
         rd_value[pmsnap_pkg::IRQ_W-1:0] = state.irq_status;
      end else if (addr == pmsnap_pkg::OFF_IRQ_MASK) begin
         rd_value[pmsnap_pkg::IRQ_W-1:0] = state.irq_mask;
      end else if (in_block(addr, pmsnap_pkg::OFF_STATUS_COPY)) begin
         rd_value[pmsnap_pkg::BIT_NO_CAPTURE] = state.no_capture[word_index(addr)];
      end else if (in_block(addr, pmsnap_pkg::OFF_OVF_COPY)) begin
         rd_value[7:0] = state.ovf_copy[word_index(addr)];
      end else begin
         mapped = 1'b0;
      end
      if (addr[1:0] != 2'h0) begin
         mapped = 1'b0;
      end
   end

   // ==========================================================
   // Capture sources
   assign req_rise    = state.req_sync[1] && !state.req_seen;
   assign sw_capture  = wr && addr == pmsnap_pkg::OFF_CAPTURE && wbits[pmsnap_pkg::BIT_CAPTURE];
   assign ovf_capture = |(overflow_pulse & state.trig_en);
   assign capture     = sw_capture || req_rise || ovf_capture;

   // ==========================================================
   // Next state
   always_comb begin
      next_state = state;

      // Snapshot request crosses two flops before the edge detector
      next_state.req_sync = {state.req_sync[0], snapshot_request_in};
      next_state.req_seen = state.req_sync[1];

      // Bus answer prepared in the setup cycle
      if (setup) begin
         next_state.ready = 1'b1;
         next_state.err   = !mapped || !allowed;
         next_state.rdata = (mapped && allowed && !apb_req.pwrite) ? rd_value : 32'h0000_0000;
         if (addr == pmsnap_pkg::OFF_SECURE_CTRL && apb_req.pprot[1]) begin
            next_state.err   = 1'b1;
            next_state.rdata = 32'h0000_0000;
         end
      end else if (commit) begin
         next_state.ready = 1'b0;
         next_state.err   = 1'b0;
         next_state.rdata = 32'h0000_0000;
      end

      // Register writes
      if (wr) begin
         unique case (addr)
            pmsnap_pkg::OFF_ENABLE_SET: begin
               next_state.enable.cycle  = state.enable.cycle | wbits[pmsnap_pkg::BIT_CYCLE_EN];
               next_state.enable.events = state.enable.events | wbits[7:0];
            end
            pmsnap_pkg::OFF_ENABLE_CLR: begin
               next_state.enable.cycle  = state.enable.cycle & ~wbits[pmsnap_pkg::BIT_CYCLE_EN];
               next_state.enable.events = state.enable.events & ~wbits[7:0];
            end
            pmsnap_pkg::OFF_SECURE_CTRL: begin
               next_state.secure_ctrl = wbits[1:0];
            end
            pmsnap_pkg::OFF_OVF_TRIG_EN: begin
               next_state.trig_en = wbits[7:0];
            end
            pmsnap_pkg::OFF_IRQ_MASK: begin
               next_state.irq_mask = wbits[pmsnap_pkg::IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // All shadows load together
      if (capture) begin
         next_state.cyc_snap = counts.cycle;
         next_state.evt_snap = counts.events;
         for (int n = 0; n < pmsnap_pkg::NUM_EVENTS; n++) begin
            next_state.ovf_copy[n]   = counts.overflow;
            next_state.no_capture[n] = !state.enable.events[n];
         end
      end

      // Read clears, a same-cycle event wins
      if (commit && !apb_req.pwrite && !state.err && addr == pmsnap_pkg::OFF_IRQ_STATUS) begin
         next_state.irq_status = '0;
      end
      if (capture) begin
         next_state.irq_status[pmsnap_pkg::BIT_IRQ_CAPTURE] = 1'b1;
      end
      if (setup && mapped && !allowed) begin
         next_state.irq_status[pmsnap_pkg::BIT_IRQ_DENIED] = 1'b1;
      end
      next_state.irq = |(next_state.irq_status & state.irq_mask);
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state                <= '0;
         state.no_capture     <= {8{pmsnap_pkg::RST_NO_CAPTURE}};
         state.enable.cycle   <= pmsnap_pkg::RST_CYCLE_EN;
         state.enable.events  <= pmsnap_pkg::RST_EVENT_EN;
         state.secure_ctrl    <= pmsnap_pkg::RST_SECURE;
         state.trig_en        <= pmsnap_pkg::RST_TRIG_EN;
         state.irq_mask       <= pmsnap_pkg::RST_IRQ_MASK;
      end else begin
         state <= next_state;
      end
   end

   assign prdata         = state.rdata;
   assign pready         = state.ready;
   assign pslverr        = state.err;
   assign counter_enable = state.enable;
   assign irq            = state.irq;

endmodule : pmsnap_regs

// ==== pkg/pmsnap_pkg.sv ====
// Package of the snapshot and count-enable register bank.
// Assumes a 32-bit APB slave port clocked by pclk.
package pmsnap_pkg;

   // ==========================================================
   // Sizes
   localparam int unsigned NUM_EVENTS = 8;
   localparam int unsigned ADDR_W     = 12;

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] OFF_SNAP_STATUS  = 12'h610;
   localparam logic [11:0] OFF_OVF_SNAP     = 12'h614;
   localparam logic [11:0] OFF_CYC_SNAP_LO  = 12'h618;
   localparam logic [11:0] OFF_CYC_SNAP_HI  = 12'h61c;
   localparam logic [11:0] OFF_EVT_SNAP     = 12'h620;
   localparam logic [11:0] OFF_CAPTURE      = 12'h6f0;
   localparam logic [11:0] OFF_ENABLE_SET   = 12'hc00;
   localparam logic [11:0] OFF_ENABLE_CLR   = 12'hc20;
   localparam logic [11:0] OFF_SECURE_CTRL  = 12'hf00;
   localparam logic [11:0] OFF_OVF_TRIG_EN  = 12'hf08;
   localparam logic [11:0] OFF_IRQ_STATUS   = 12'hf10;
   localparam logic [11:0] OFF_IRQ_MASK     = 12'hf14;
   localparam logic [11:0] OFF_STATUS_COPY  = 12'hf40;
   localparam logic [11:0] OFF_OVF_COPY     = 12'hf60;

   // ==========================================================
   // Field positions
   localparam int unsigned BIT_NO_CAPTURE   = 0;
   localparam int unsigned BIT_CAPTURE      = 0;
   localparam int unsigned BIT_CYCLE_EN     = 31;
   localparam int unsigned BIT_NS_OVERRIDE  = 0;
   localparam int unsigned BIT_NS_DEBUG     = 1;
   localparam int unsigned BIT_IRQ_CAPTURE  = 0;
   localparam int unsigned BIT_IRQ_DENIED   = 1;
   localparam int unsigned IRQ_W            = 2;

   // ==========================================================
   // Reset values
   localparam logic       RST_NO_CAPTURE = 1'b1;
   localparam logic [7:0] RST_EVENT_EN   = 8'h00;
   localparam logic       RST_CYCLE_EN   = 1'b0;
   localparam logic [1:0] RST_SECURE     = 2'h0;
   localparam logic [7:0] RST_TRIG_EN    = 8'h00;
   localparam logic [1:0] RST_IRQ_MASK   = 2'h0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [63:0]                 cycle;
      logic [NUM_EVENTS-1:0][31:0] events;
      logic [NUM_EVENTS-1:0]       overflow;
   } pmsnap_counts_t;

   typedef struct packed {
      logic                  cycle;
      logic [NUM_EVENTS-1:0] events;
   } pmsnap_enable_t;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [31:0]       pwdata;
      logic [3:0]        pstrb;
      logic [2:0]        pprot;
   } pmsnap_apb_req_t;

endpackage : pmsnap_pkg

// ==== verif/pmsnap_partner.sv ====
// Far-side model: live counters and the snapshot request level.
// Assumes one pclk domain; go is a one-cycle request from the bench.
`timescale 1ns/100ps
module pmsnap_partner (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  go,
   output logic                       snapshot_request_in,
   output pmsnap_pkg::pmsnap_counts_t counts
);
   logic [63:0] cyc;
   logic [2:0]  hold;
   // ==========================================================
   // Request held 4 cycles, then low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc  <= 64'h0000_0007_0000_0000;
         hold <= 3'h0;
      end else begin
         cyc <= cyc + 64'h1;
         if (go) hold <= 3'h4;
         else if (hold != 3'h0) hold <= hold - 3'h1;
      end
   end
   assign snapshot_request_in = (hold != 3'h0);
   // Event n runs at cycle low half plus n
   always_comb begin
      counts.cycle    = cyc;
      counts.overflow = 8'ha5;
      for (int i = 0; i < 8; i++) counts.events[i] = cyc[31:0] + 32'(i);
   end
endmodule : pmsnap_partner

// ==== verif/pmsnap_monitor.sv ====
// Checker of the register bank ports.
// Assumes the bind below attaches it to every pmsnap_regs.
`timescale 1ns/100ps
module pmsnap_monitor (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire pmsnap_pkg::pmsnap_apb_req_t apb_req,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire pmsnap_pkg::pmsnap_enable_t counter_enable,
   input wire logic                       irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire setup = apb_req.psel & !apb_req.penable;
   wire acc   = apb_req.psel & apb_req.penable & pready;
   wire wr_ok = acc & apb_req.pwrite & !apb_req.pprot[1] & !pslverr & (apb_req.pstrb == 4'hf);
   wire on_set = apb_req.paddr == pmsnap_pkg::OFF_ENABLE_SET;
   wire on_clr = apb_req.paddr == pmsnap_pkg::OFF_ENABLE_CLR;
   // ==========================================================
   // Assertions
   ready_after_setup_a: assert property (setup |=> pready) else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
   misalign_err_a: assert property (setup && apb_req.paddr[1:0] != 2'h0 |=> pslverr) else $error("no error");
   cycle_set_a: assert property (wr_ok & on_set & apb_req.pwdata[31] |=> counter_enable.cycle)
      else $error("cycle enable not set");
   cycle_clr_a: assert property (wr_ok & on_clr & apb_req.pwdata[31] |=> !counter_enable.cycle)
      else $error("cycle enable not cleared");
   event_set_a: assert property (wr_ok & on_set |=>
      (counter_enable.events & $past(apb_req.pwdata[7:0])) == $past(apb_req.pwdata[7:0]))
      else $error("event enable not set");
   event_clr_a: assert property (wr_ok & on_clr |=>
      (counter_enable.events & $past(apb_req.pwdata[7:0])) == 8'h0)
      else $error("event enable not cleared");
   enable_hold_a: assert property (!(acc & apb_req.pwrite) |=> $stable(counter_enable))
      else $error("enable changed without write");
   enable_read_a: assert property (acc & !apb_req.pwrite & on_set & !pslverr |->
      prdata == {counter_enable.cycle, 23'h0, counter_enable.events}) else $error("enable readback");
   cover property (acc & pslverr);
   cover property (wr_ok & on_clr);
   cover property ($rose(irq));
endmodule : pmsnap_monitor
bind pmsnap_regs pmsnap_monitor mon (.pclk, .presetn, .apb_req, .prdata, .pready, .pslverr, .counter_enable, .irq);

// ==== verif/pmsnap_regs_bench.sv ====
// Self-checking bench of the register bank.
// Assumes package, design, partner and checker are compiled first.
`timescale 1ns/100ps
module pmsnap_regs_bench;
   logic                        pclk = 1'b0;
   logic                        presetn = 1'b0;
   logic                        go = 1'b0;
   logic [7:0]                  ovf = 8'h00;
   pmsnap_pkg::pmsnap_apb_req_t q = '0;
   pmsnap_pkg::pmsnap_counts_t  counts;
   pmsnap_pkg::pmsnap_enable_t  en;
   logic [31:0]                 prdata, rd, l;
   logic                        pready, pslverr, irq, snap, er;
   int                          bad_count = 0;
   int                          compares = 0;
   int                          cyc = 0;
   always #2.5 pclk = ~pclk;
   pmsnap_partner far (.pclk, .presetn, .go, .snapshot_request_in(snap), .counts);
   pmsnap_regs dut (.pclk, .presetn, .apb_req(q), .prdata, .pready, .pslverr, .counts,
      .overflow_pulse(ovf), .snapshot_request_in(snap), .counter_enable(en), .irq);
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] p = 3'h0);
      @(posedge pclk);
      q <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d, pstrb: 4'hf, pprot: p};
      @(posedge pclk);
      q.penable <= 1'b1;
      // Request stands until the edge that sees pready high
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      q.psel    <= 1'b0;
      q.penable <= 1'b0;
   endtask : apb
   task automatic complete_run;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      apb(0, 12'hc00, 0); chk(rd, 32'h0);
      apb(0, 12'h610, 0); chk(rd, 32'h1);
      apb(0, 12'h004, 0); chk(32'(er), 32'h1);
      apb(0, 12'h622, 0); chk(32'(er), 32'h1);
      $display("reset test done");
   endtask : t_reset
   task automatic t_enable;
      apb(1, 12'hc00, 32'h8000_0081);
      apb(1, 12'hc00, 32'h0);
      apb(0, 12'hc20, 0); chk(rd, 32'h8000_0081);
      apb(1, 12'hc20, 32'h1);
      apb(0, 12'hc00, 0); chk(rd, 32'h8000_0080);
      apb(1, 12'hc20, 32'h8000_0000);
      apb(0, 12'hc20, 0); chk(rd, 32'h80);
      chk(32'(en), 32'h80);
      $display("enable test done");
   endtask : t_enable
   task automatic t_swcap;
      apb(1, 12'hc00, 32'hff);
      apb(1, 12'hf14, 32'h1);
      apb(1, 12'h6f0, 32'h1);
      apb(0, 12'h610, 0); chk(rd, 32'h0);
      apb(0, 12'h614, 0); chk(rd, 32'ha5);
      apb(0, 12'h61c, 0); chk(rd, 32'h7);
      apb(0, 12'h618, 0);
      l = rd;
      for (int n = 0; n < 8; n++) begin
         apb(0, 12'h620 + 12'(4 * n), 0); chk(rd, l + 32'(n));
      end
      chk(32'(irq), 32'h1);
      apb(0, 12'hf10, 0); chk(rd, 32'h1);
      apb(0, 12'hf10, 0); chk(32'(irq), 32'h0); chk(rd, 32'h0);
      $display("software capture test done");
   endtask : t_swcap
   task automatic t_hwcap;
      apb(1, 12'hc20, 32'h8);
      @(posedge pclk) go <= 1'b1;
      @(posedge pclk) go <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(0, 12'hf40, 0); chk(rd, 32'h0);
      apb(0, 12'hf4c, 0); chk(rd, 32'h1);
      apb(0, 12'hf6c, 0); chk(rd, 32'ha5);
      apb(0, 12'h618, 0);
      l = rd;
      apb(0, 12'h63c, 0); chk(rd, l + 32'h7);
      apb(0, 12'hf10, 0); chk(rd, 32'h1);
      $display("request capture test done");
   endtask : t_hwcap
   task automatic t_ovf;
      apb(1, 12'hf08, 32'h4);
      @(posedge pclk) ovf <= 8'h08;
      @(posedge pclk) ovf <= 8'h00;
      apb(0, 12'hf10, 0); chk(rd, 32'h0);
      @(posedge pclk) ovf <= 8'h04;
      @(posedge pclk) ovf <= 8'h00;
      apb(0, 12'hf10, 0); chk(rd, 32'h1);
      $display("overflow trigger test done");
   endtask : t_ovf
   task automatic t_secure;
      for (int k = 0; k < 3; k++) begin
         apb(1, 12'hf00, 32'(k));
         apb(0, 12'hc00, 0, 3'h2); chk(32'(er), 32'(k == 0));
      end
      apb(0, 12'hf10, 0); chk(rd, 32'h2);
      $display("secure access test done");
   endtask : t_secure
   // ==========================================================
   // Main sequence and hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_enable();
      t_swcap();
      t_hwcap();
      t_ovf();
      t_secure();
      complete_run();
   end
endmodule : pmsnap_regs_bench
